// File: uodc_defines.vh
`ifndef UODC_DEFINES_VH
`define UODC_DEFINES_VH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define UODC_ADDR_W        5
`define UODC_OFF_CTRL      5'h00
`define UODC_OFF_OTG       5'h01
`define UODC_OFF_PWR       5'h02
`define UODC_OFF_IRQ_FLAG  5'h03
`define UODC_OFF_IRQ_EN    5'h04
`define UODC_OFF_ERR_FLAG  5'h05
`define UODC_OFF_ERR_EN    5'h06
`define UODC_OFF_EP0       5'h07
`define UODC_OFF_DEVADDR   5'h08
`define UODC_OFF_ENDPOINT_STALL_FLAG   5'h09
`define UODC_OFF_FRAME     5'h0a
`define UODC_DESC_SEL      4
`define UODC_DESC_IDX_W    4

// ----------------------------------------------------------------------
// Module control bits
// ----------------------------------------------------------------------
`define UODC_CTL_ENABLE    0
`define UODC_CTL_PPRST     1
`define UODC_CTL_HOST      3
`define UODC_CTL_BUSRST    4
`define UODC_CTL_LINE_J_STATE_BIT    7

// ----------------------------------------------------------------------
// OTG control bits
// ----------------------------------------------------------------------
`define UODC_OTG_OTG_FUNCTION_ENABLE     2
`define UODC_OTG_DMPD      4
`define UODC_OTG_DPPD      5
`define UODC_OTG_DMPU      6
`define UODC_OTG_DPPU      7

// ----------------------------------------------------------------------
// Endpoint zero control and address bits
// ----------------------------------------------------------------------
`define UODC_EP0_HSHK      0
`define UODC_EP0_TXEN      2
`define UODC_EP0_RXEN      3
`define UODC_EP0_LOW_SPEED_ENDPOINT_SELECT      7
`define UODC_ADR_LOW_SPEED_ADDRESS_ENABLE    7

// ----------------------------------------------------------------------
// Top level flag bits
// ----------------------------------------------------------------------
`define UODC_IRQ_ERR       1
`define UODC_IRQ_SOF       2
`define UODC_IRQ_TRN       3
`define UODC_IRQ_STALL     5
`define UODC_IRQ_ATTACH    6

// ----------------------------------------------------------------------
// Descriptor status word layout
// ----------------------------------------------------------------------
`define UODC_BD_OWN        15
`define UODC_BD_TOG        14
`define UODC_BD_TOGEN      11
`define UODC_BD_STALL      10
`define UODC_BD_PID_HI     13
`define UODC_BD_PID_LO     10
`define UODC_BD_BC_HI      9
`define UODC_BD_BC_LO      0

// ----------------------------------------------------------------------
// Token identifiers and handshake codes
// ----------------------------------------------------------------------
`define UODC_PID_OUT       4'h1
`define UODC_PID_IN        4'h9
`define UODC_PID_SETUP     4'hd
`define UODC_HS_ACK        2'h0
`define UODC_HS_NAK        2'h1
`define UODC_HS_STALL      2'h2
`define UODC_HS_DATA       2'h3

// ----------------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------------
`define UODC_FRAME_LOAD    14'h2ee0
`define UODC_BIT_DIV       8'h15

`endif

// File: uodc_core.v
// Overview of operation
// [R01] Cleared owner flag: descriptor fields ignored.
// [R02] Toggle select ignored unless checking enabled; IN answers send it as tx_toggle even with checking off.
// [R03] Checking on: wrong toggle packets ignored.
// [R04] Buffer stall: STALL, descriptor left unchanged.
// [R05] Buffer stall handshake sets endpoint stall flag.
// [R06] Software keeps reserved status bits zero.
// [R07] Byte count replaced by bytes actually moved.
// [R08] All interrupt sources share one request.
// [R09] Two levels; any error sets summary.
// [R10] Flags hardware set, write one clears.
// [R11] Device mode finishes control status phase alone.
// [R12] Pointer reset bit returns ping-pong pointers.
// [R13] Software bring-up: masks, flags, enables.
// [R14] Software then enables endpoint zero, power, pull-up.
// [R15] IN token on owned descriptor sends buffer.
// [R16] OUT token on owned descriptor stores data.
// [R17] Host transfers use endpoint zero only.
// [R18] Host enable exposes host-only control bits.
// [R19] Host frames load 12000; enable bit stops them.
// [R20] Host pull-downs; low-to-high line sets attach.
// [R21] Software waits, reads line state, sets low speed.
// [R22] Bus reset bit drives reset signalling.
// [R23] Completion writes token PID and byte count.
// [R24] Software leaves owned descriptors alone.
// [R25] Completion clears owner with transfer flag.
// [R26] Write-one-clear touches only written ones.
`include "uodc_defines.vh"
`default_nettype none

module uodc_core #(
	parameter EP_W    = 2,
	parameter ERR_N   = 8,
	parameter BIT_DIV = `UODC_BIT_DIV
) (
	// Clock and reset
	input  wire                    core_clk,
	input  wire                    nrst,
	// Register port
	input  wire [`UODC_ADDR_W-1:0] reg_addr,
	input  wire [15:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output wire [15:0]             reg_rdata,
	// Token events from the serial engine
	input  wire                    tok_valid,
	input  wire [3:0]              tok_pid,
	input  wire [EP_W-1:0]         tok_ep,
	input  wire                    tok_status_phase,
	input  wire                    pkt_toggle,
	input  wire [9:0]              pkt_count,
	input  wire [ERR_N-1:0]        err_event,
	// Answer to the serial engine
	output wire                    hs_valid,
	output wire [1:0]              hs_code,
	output wire [9:0]              tx_count,
	output wire                    tx_toggle,
	// Bus line state and pins
	input  wire                    line_dp,
	input  wire                    line_dm,
	output wire                    dplus_pullup_enable,
	output wire                    dminus_pullup_enable,
	output wire                    dplus_pulldown_enable,
	output wire                    dminus_pulldown_enable,
	output wire                    bus_reset_out,
	output wire                    sof_pulse,
	output wire                    module_power_out,
	output wire [(2<<EP_W)-1:0]    pp_pointer,
	// Interrupt request
	output wire                    irq
);

	localparam EP_N   = 1 << EP_W;
	localparam DIDX_W = EP_W + 2;
	localparam DESC_N = 1 << DIDX_W;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [7:0]        ctrl_reg;
	reg  [7:0]        otg_reg;
	reg               pwr_reg;
	reg  [7:0]        irq_flag_reg;
	reg  [7:0]        irq_en_reg;
	reg  [ERR_N-1:0]  err_flag_reg;
	reg  [ERR_N-1:0]  err_en_reg;
	reg  [7:0]        ep0_reg;
	reg  [7:0]        devaddr_reg;
	reg  [EP_N-1:0]   ep_stall_reg;
	reg  [15:0]       desc_reg [0:DESC_N-1];
	reg  [EP_N*2-1:0] pp_reg;
	reg  [15:0]       rdata_reg;
	reg               hs_valid_reg;
	reg  [1:0]        hs_code_reg;
	reg  [9:0]        tx_count_reg;
	reg               tx_toggle_reg;
	reg  [13:0]       frame_reg;
	reg  [7:0]        div_reg;
	reg               sof_reg;
	reg               dp_prev_reg;
	reg               dm_prev_reg;
	integer           i;

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	wire host_mode  = ctrl_reg[`UODC_CTL_HOST];
	wire dev_active = ctrl_reg[`UODC_CTL_ENABLE] & ~host_mode & pwr_reg;
	wire sof_on     = host_mode & ctrl_reg[`UODC_CTL_ENABLE]; // R18
	wire is_desc    = reg_addr[`UODC_DESC_SEL];
	wire [`UODC_DESC_IDX_W-1:0] cpu_idx = reg_addr[`UODC_DESC_IDX_W-1:0];

	// ------------------------------------------------------------------
	// Token decode
	// ------------------------------------------------------------------
	wire [EP_W-1:0]   ep      = host_mode ? {EP_W{1'b0}} : tok_ep; // R17
	wire              dir_in  = (tok_pid == `UODC_PID_IN);
	wire              is_out  = (tok_pid == `UODC_PID_OUT) | (tok_pid == `UODC_PID_SETUP);
	wire [EP_W:0]     pp_idx  = {ep, dir_in};
	wire [DIDX_W-1:0] d_idx   = {ep, dir_in, pp_reg[pp_idx]};
	wire [15:0]       d_word  = desc_reg[d_idx];
	wire              ep_zero = (ep == {EP_W{1'b0}});
	wire              ep0_blk = ep_zero & (dir_in ? ~ep0_reg[`UODC_EP0_TXEN]
	                                               : ~ep0_reg[`UODC_EP0_RXEN]);
	wire              tok_ok  = tok_valid & (dev_active | host_mode) & (dir_in | is_out);
	wire              owned   = d_word[`UODC_BD_OWN]; // R01
	wire              stall   = owned & d_word[`UODC_BD_STALL]; // R04
	wire              tog_bad = d_word[`UODC_BD_TOGEN] &
	                            (pkt_toggle != d_word[`UODC_BD_TOG]); // R02 R03
	wire              status  = tok_ok & ~host_mode & ep_zero & tok_status_phase; // R11

	reg               do_nak;
	reg               do_stall;
	reg               do_done;
	reg  [9:0]        done_cnt;

	always @* begin
		do_nak   = 1'b0;
		do_stall = 1'b0;
		do_done  = 1'b0;
		done_cnt = d_word[`UODC_BD_BC_HI:`UODC_BD_BC_LO];
		if (tok_ok && !status && !ep0_blk) begin
			if (!owned) begin
				do_nak = 1'b1; // R01
			end else if (stall) begin
				do_stall = 1'b1; // R04
			end else if (dir_in) begin
				do_done = 1'b1; // R15
			end else if (!tog_bad) begin
				do_done  = 1'b1; // R16
				done_cnt = pkt_count; // R07
			end
		end
	end

	// ------------------------------------------------------------------
	// Handshake answer
	// ------------------------------------------------------------------
	wire hs_en = ~ep_zero | ep0_reg[`UODC_EP0_HSHK];

	always @(posedge core_clk) begin
		if (!nrst) begin
			hs_valid_reg  <= 1'b0;
			hs_code_reg   <= `UODC_HS_ACK;
			tx_count_reg  <= 10'h000;
			tx_toggle_reg <= 1'b0;
		end else begin
			hs_valid_reg <= hs_en & (status | do_nak | do_stall | do_done);
			if (status) begin
				hs_code_reg   <= dir_in ? `UODC_HS_DATA : `UODC_HS_ACK; // R11
				tx_count_reg  <= dir_in ? 10'h000 : tx_count_reg;
				tx_toggle_reg <= dir_in | tx_toggle_reg;
			end else if (do_stall) begin
				hs_code_reg <= `UODC_HS_STALL; // R04
			end else if (do_nak) begin
				hs_code_reg <= `UODC_HS_NAK;
			end else if (do_done && dir_in) begin
				hs_code_reg   <= `UODC_HS_DATA; // R15
				tx_count_reg  <= done_cnt;
				tx_toggle_reg <= d_word[`UODC_BD_TOG];
			end else if (do_done) begin
				hs_code_reg <= `UODC_HS_ACK; // R16
			end
		end
	end

	// ------------------------------------------------------------------
	// Descriptor table and ping-pong pointers
	// ------------------------------------------------------------------
	always @(posedge core_clk) begin
		if (!nrst) begin
			for (i = 0; i < DESC_N; i = i + 1) begin
				desc_reg[i] <= 16'h0000;
			end
			pp_reg <= {EP_N*2{1'b0}};
		end else begin
			if (reg_wr && is_desc) begin
				desc_reg[cpu_idx] <= reg_wdata;
			end
			if (do_done) begin
				desc_reg[d_idx] <= {1'b0, d_word[`UODC_BD_TOG], tok_pid, done_cnt}; // R23 R25
			end
			if (ctrl_reg[`UODC_CTL_PPRST]) begin
				pp_reg <= {EP_N*2{1'b0}}; // R12
			end else if (do_done) begin
				pp_reg[pp_idx] <= ~pp_reg[pp_idx];
			end
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	wire [7:0] ctrl_host_mask = {3'h0, host_mode, 4'hf}; // R18

	always @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_reg    <= 8'h00;
			otg_reg     <= 8'h00;
			pwr_reg     <= 1'b0;
			irq_en_reg  <= 8'h00;
			err_en_reg  <= {ERR_N{1'b0}};
			ep0_reg     <= 8'h00;
			devaddr_reg <= 8'h00;
		end else if (reg_wr && !is_desc) begin
			case (reg_addr)
				`UODC_OFF_CTRL: begin
					ctrl_reg <= reg_wdata[7:0] & ctrl_host_mask & 8'h7f;
				end
				`UODC_OFF_OTG: begin
					otg_reg <= reg_wdata[7:0];
				end
				`UODC_OFF_PWR: begin
					pwr_reg <= reg_wdata[0];
				end
				`UODC_OFF_IRQ_EN: begin
					irq_en_reg <= reg_wdata[7:0];
				end
				`UODC_OFF_ERR_EN: begin
					err_en_reg <= reg_wdata[ERR_N-1:0];
				end
				`UODC_OFF_EP0: begin
					ep0_reg <= reg_wdata[7:0];
				end
				`UODC_OFF_DEVADDR: begin
					devaddr_reg <= reg_wdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Frame start generation
	// ------------------------------------------------------------------
	always @(posedge core_clk) begin
		if (!nrst) begin
			frame_reg <= `UODC_FRAME_LOAD;
			div_reg   <= 8'h00;
			sof_reg   <= 1'b0;
		end else if (!sof_on) begin
			frame_reg <= `UODC_FRAME_LOAD; // R19
			div_reg   <= 8'h00;
			sof_reg   <= 1'b0;
		end else if (div_reg == BIT_DIV[7:0] - 8'h01) begin
			div_reg <= 8'h00;
			if (frame_reg == 14'h0001) begin
				frame_reg <= `UODC_FRAME_LOAD; // R19
				sof_reg   <= 1'b1;
			end else begin
				frame_reg <= frame_reg - 14'h0001;
				sof_reg   <= 1'b0;
			end
		end else begin
			div_reg <= div_reg + 8'h01;
			sof_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------------
	wire attach_ev = host_mode & ((line_dp & ~dp_prev_reg) | (line_dm & ~dm_prev_reg)); // R20
	wire wr_irq    = reg_wr & (reg_addr == `UODC_OFF_IRQ_FLAG);
	wire wr_err    = reg_wr & (reg_addr == `UODC_OFF_ERR_FLAG);
	wire wr_stl    = reg_wr & (reg_addr == `UODC_OFF_ENDPOINT_STALL_FLAG);
	wire [7:0] irq_set;

	assign irq_set = {1'b0, attach_ev, do_stall, 1'b0, do_done, sof_reg, 2'h0};

	always @(posedge core_clk) begin
		if (!nrst) begin
			irq_flag_reg <= 8'h00;
			err_flag_reg <= {ERR_N{1'b0}};
			ep_stall_reg <= {EP_N{1'b0}};
			dp_prev_reg  <= 1'b0;
			dm_prev_reg  <= 1'b0;
		end else begin
			dp_prev_reg <= line_dp;
			dm_prev_reg <= line_dm;
			irq_flag_reg <= (irq_flag_reg & ~({8{wr_irq}} & reg_wdata[7:0])) | irq_set; // R10 R26
			err_flag_reg <= (err_flag_reg & ~({ERR_N{wr_err}} & reg_wdata[ERR_N-1:0]))
			                | err_event; // R10 R26
			ep_stall_reg <= (ep_stall_reg & ~({EP_N{wr_stl}} & reg_wdata[EP_N-1:0]))
			                | ({{(EP_N-1){1'b0}}, do_stall} << ep); // R05
		end
	end

	wire       err_sum  = |err_flag_reg; // R09
	wire [7:0] irq_view = irq_flag_reg | ({7'h00, err_sum} << `UODC_IRQ_ERR);
	wire       err_irq  = |(err_flag_reg & err_en_reg);

	assign irq = |(irq_view & irq_en_reg & ~(8'h01 << `UODC_IRQ_ERR))
	             | (err_irq & irq_en_reg[`UODC_IRQ_ERR]); // R08 R09

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	reg [15:0] rd_mux;

	always @* begin
		rd_mux = 16'h0000;
		if (is_desc) begin
			rd_mux = desc_reg[cpu_idx];
		end else begin
			case (reg_addr)
				`UODC_OFF_CTRL: begin
					rd_mux = {8'h00, line_dp, ctrl_reg[6:0]}; // R21
				end
				`UODC_OFF_OTG: begin
					rd_mux = {8'h00, otg_reg};
				end
				`UODC_OFF_PWR: begin
					rd_mux = {15'h0000, pwr_reg};
				end
				`UODC_OFF_IRQ_FLAG: begin
					rd_mux = {8'h00, irq_view};
				end
				`UODC_OFF_IRQ_EN: begin
					rd_mux = {8'h00, irq_en_reg};
				end
				`UODC_OFF_ERR_FLAG: begin
					rd_mux[ERR_N-1:0] = err_flag_reg;
				end
				`UODC_OFF_ERR_EN: begin
					rd_mux[ERR_N-1:0] = err_en_reg;
				end
				`UODC_OFF_EP0: begin
					rd_mux = {8'h00, ep0_reg};
				end
				`UODC_OFF_DEVADDR: begin
					rd_mux = {8'h00, devaddr_reg};
				end
				`UODC_OFF_ENDPOINT_STALL_FLAG: begin
					rd_mux[EP_N-1:0] = ep_stall_reg;
				end
				`UODC_OFF_FRAME: begin
					rd_mux = {2'h0, frame_reg};
				end
				default: begin
					rd_mux = 16'h0000;
				end
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata              = rdata_reg;
	assign hs_valid               = hs_valid_reg;
	assign hs_code                = hs_code_reg;
	assign tx_count               = tx_count_reg;
	assign tx_toggle              = tx_toggle_reg;
	assign dplus_pullup_enable    = otg_reg[`UODC_OTG_DPPU] & ~host_mode; // R20
	assign dminus_pullup_enable   = otg_reg[`UODC_OTG_DMPU] & ~host_mode; // R20
	assign dplus_pulldown_enable  = otg_reg[`UODC_OTG_DPPD];
	assign dminus_pulldown_enable = otg_reg[`UODC_OTG_DMPD];
	assign bus_reset_out          = host_mode & ctrl_reg[`UODC_CTL_BUSRST]; // R22
	assign sof_pulse              = sof_reg;
	assign module_power_out       = pwr_reg;
	assign pp_pointer             = pp_reg;

endmodule

`default_nettype wire

// File: uodc_core_sva.sv
`include "uodc_defines.vh"
`default_nettype none
module uodc_core_sva #(
	parameter EP_W = 2
) (
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              nrst,
	// Watched ports
	input wire logic              reg_rd,
	input wire logic [15:0]       reg_rdata,
	input wire logic              tok_valid,
	input wire logic [3:0]        tok_pid,
	input wire logic              tok_status_phase,
	input wire logic              hs_valid,
	input wire logic [1:0]        hs_code,
	input wire logic [9:0]        tx_count,
	input wire logic              tx_toggle,
	input wire logic              sof_pulse,
	input wire logic              bus_reset_out,
	input wire logic              dplus_pullup_enable,
	input wire logic              dminus_pullup_enable,
	input wire logic [(2<<EP_W)-1:0] pp_pointer
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	hs_has_cause_a: assert property (
		hs_valid |-> $past(tok_valid))
		else $error("answer without a token");
	status_in_a: assert property (
		hs_valid && $past(tok_valid && tok_status_phase && tok_pid == `UODC_PID_IN)
		|-> hs_code == `UODC_HS_DATA && tx_count == 10'h000 && tx_toggle)
		else $error("status phase IN answer wrong");
	status_out_a: assert property (
		hs_valid && $past(tok_valid && tok_status_phase && tok_pid == `UODC_PID_OUT)
		|-> hs_code == `UODC_HS_ACK)
		else $error("status phase OUT answer wrong");
	tx_hold_a: assert property (
		hs_valid && hs_code != `UODC_HS_DATA |-> $stable(tx_count) && $stable(tx_toggle))
		else $error("transmit fields moved without data answer");
	sof_gap_a: assert property (
		sof_pulse |=> !sof_pulse [*8])
		else $error("frame pulses too close");
	read_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside answer cycle");
	host_pullup_a: assert property (
		bus_reset_out |-> !dplus_pullup_enable && !dminus_pullup_enable)
		else $error("pull-up on while driving bus reset");
	reset_clear_a: assert property (disable iff (1'b0)
		!nrst |=> !hs_valid && !sof_pulse && !bus_reset_out && reg_rdata == 16'h0000
		&& pp_pointer == '0)
		else $error("outputs not cleared by reset");
endmodule
bind uodc_core uodc_core_sva #(.EP_W(EP_W)) sva_chk (.core_clk, .nrst, .reg_rd, .reg_rdata,
	.tok_valid, .tok_pid, .tok_status_phase, .hs_valid, .hs_code, .tx_count, .tx_toggle,
	.sof_pulse, .bus_reset_out, .dplus_pullup_enable, .dminus_pullup_enable, .pp_pointer);
`default_nettype wire

// File: uodc_bus_peer.sv
`default_nettype none
module uodc_bus_peer (
	// Clock
	input wire logic       core_clk,
	// Token events
	output var logic       tok_valid,
	output var logic [3:0] tok_pid,
	output var logic [1:0] tok_ep,
	output var logic       tok_status_phase,
	output var logic       pkt_toggle,
	output var logic [9:0] pkt_count,
	// Bus lines
	output var logic       line_dp,
	output var logic       line_dm
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tok_valid = 1'b0;
		{tok_pid, tok_ep, tok_status_phase, pkt_toggle, pkt_count} = '0;
		line_dp = 1'b0;
		line_dm = 1'b0;
	end
	// Sends one token with its packet result; fields are scrambled outside the pulse.
	task automatic send(input logic [3:0] p, input logic [1:0] e, input logic s, t,
		input logic [9:0] c);
		@(posedge core_clk);
		tok_valid <= 1'b1;
		{tok_pid, tok_ep, tok_status_phase, pkt_toggle, pkt_count} <= {p, e, s, t, c};
		@(posedge core_clk);
		tok_valid <= 1'b0;
		{tok_pid, tok_ep, tok_status_phase, pkt_toggle, pkt_count} <= ~{p, e, s, t, c};
	endtask
	// Moves the lines from SE0 to a J state as an attaching device does.
	task automatic attach();
		@(posedge core_clk);
		line_dp <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: uodc_core_test.sv
`include "uodc_defines.vh"
`default_nettype none
module uodc_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// Signals
	// --------
	logic                    core_clk = 1'b0;
	logic                    nrst = 1'b0;
	logic [`UODC_ADDR_W-1:0] reg_addr = '0;
	logic [15:0]             reg_wdata = '0;
	logic                    reg_wr = 1'b0;
	logic                    reg_rd = 1'b0;
	logic [7:0]              err_event = '0;
	logic [15:0]             last;
	wire logic [15:0]        reg_rdata;
	wire logic [9:0]         pkt_count, tx_count;
	wire logic [3:0]         tok_pid;
	wire logic [7:0]         pp_pointer;
	wire logic [1:0]         tok_ep, hs_code;
	wire logic               tok_valid, tok_status_phase, pkt_toggle, line_dp, line_dm;
	wire logic               hs_valid, tx_toggle, bus_reset_out, sof_pulse, irq;
	wire logic               dplus_pullup_enable, dminus_pullup_enable, module_power_out;
	wire logic               dplus_pulldown_enable, dminus_pulldown_enable;
	int                      fails = 0, total_checks = 0, n;
	localparam logic [36:0] rows [7] = '{{5'h0b, 16'hffff, 16'h0000},
		{5'h03, 16'hffff, 16'h0000}, {5'h05, 16'hffff, 16'h0000},
		{5'h09, 16'hffff, 16'h0000}, {5'h0a, 16'h1234, 16'h2ee0},
		{5'h02, 16'h0001, 16'h0001}, {5'h1f, 16'h8005, 16'h8005}};
	uodc_core #(.BIT_DIV(8'h02)) dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tok_valid, .tok_pid, .tok_ep, .tok_status_phase, .pkt_toggle,
		.pkt_count, .err_event, .hs_valid, .hs_code, .tx_count, .tx_toggle, .line_dp,
		.line_dm, .dplus_pullup_enable, .dminus_pullup_enable, .dplus_pulldown_enable,
		.dminus_pulldown_enable, .bus_reset_out, .sof_pulse, .module_power_out,
		.pp_pointer, .irq);
	uodc_bus_peer peer (.core_clk, .tok_valid, .tok_pid, .tok_ep, .tok_status_phase,
		.pkt_toggle, .pkt_count, .line_dp, .line_dm);
	always #2 core_clk = ~core_clk;
	// --------
	// Tasks
	// --------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic peek(input logic [4:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 last = reg_rdata;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		peek(a);
		chk(last, e);
	endtask
	task automatic tok(input logic [3:0] p, input logic [1:0] e, input logic s, t,
		input logic [9:0] c, input logic ok, input logic [1:0] h);
		peer.send(p, e, s, t, c);
		#1 chk(hs_valid, ok);
		if (ok)
			chk(hs_code, h);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// --------
	// Tests
	// --------
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(rows[i][36:32], rows[i][31:16]);
			rd(rows[i][36:32], rows[i][15:0]);
		end
		chk(module_power_out, 1'b1);
		$display("register table done");
		wr(5'h00, 16'h0002);
		wr(5'h00, 16'h0000);
		chk(pp_pointer, 16'h0000);
		wr(5'h04, 16'h0000);
		wr(5'h06, 16'h0000);
		wr(5'h03, 16'h00ff);
		wr(5'h05, 16'h00ff);
		wr(5'h00, 16'h0011);
		rd(5'h00, 16'h0001);
		wr(5'h01, 16'h0004);
		wr(5'h07, 16'h000d);
		wr(5'h01, 16'h0084);
		chk(dplus_pullup_enable, 1'b1);
		wr(5'h16, 16'h8005);
		tok(`UODC_PID_IN, 2'h1, 1'b0, 1'b0, 10'h000, 1'b1, `UODC_HS_DATA);
		chk(tx_count, 16'h0005);
		rd(5'h16, 16'h2405);
		wr(5'h14, 16'h8403);
		tok(`UODC_PID_OUT, 2'h1, 1'b0, 1'b0, 10'h003, 1'b1, `UODC_HS_STALL);
		rd(5'h14, 16'h8403);
		rd(5'h09, 16'h0002);
		rd(5'h03, 16'h0028);
		wr(5'h03, 16'h0000);
		rd(5'h03, 16'h0028);
		wr(5'h03, 16'h0008);
		rd(5'h03, 16'h0020);
		$display("device transfers done");
		wr(5'h1a, 16'h0400);
		tok(`UODC_PID_IN, 2'h2, 1'b0, 1'b0, 10'h000, 1'b1, `UODC_HS_NAK);
		wr(5'h18, 16'h8810);
		tok(`UODC_PID_OUT, 2'h2, 1'b0, 1'b1, 10'h007, 1'b0, `UODC_HS_ACK);
		rd(5'h18, 16'h8810);
		tok(`UODC_PID_OUT, 2'h2, 1'b0, 1'b0, 10'h007, 1'b1, `UODC_HS_ACK);
		rd(5'h18, 16'h0407);
		wr(5'h1c, 16'hc002);
		tok(`UODC_PID_OUT, 2'h3, 1'b0, 1'b0, 10'h001, 1'b1, `UODC_HS_ACK);
		tok(`UODC_PID_OUT, 2'h0, 1'b1, 1'b1, 10'h000, 1'b1, `UODC_HS_ACK);
		tok(`UODC_PID_IN, 2'h0, 1'b1, 1'b0, 10'h000, 1'b1, `UODC_HS_DATA);
		chk(tx_toggle, 1'b1);
		$display("toggle and status phase done");
		wr(5'h03, 16'hffff);
		@(posedge core_clk);
		err_event <= 8'h04;
		@(posedge core_clk);
		err_event <= 8'h00;
		rd(5'h03, 16'h0002);
		rd(5'h05, 16'h0004);
		chk(irq, 1'b0);
		wr(5'h06, 16'h0004);
		wr(5'h04, 16'h0002);
		chk(irq, 1'b1);
		wr(5'h05, 16'h0004);
		rd(5'h03, 16'h0000);
		chk(irq, 1'b0);
		$display("interrupt tree done");
		wr(5'h04, 16'h0000);
		wr(5'h00, 16'h0008);
		wr(5'h01, 16'h00f0);
		chk(dplus_pullup_enable, 1'b0);
		chk(dminus_pulldown_enable, 1'b1);
		peer.attach();
		repeat (3) @(posedge core_clk);
		rd(5'h03, 16'h0040);
		rd(5'h00, 16'h0088);
		wr(5'h00, 16'h0018);
		rd(5'h00, 16'h0098);
		chk(bus_reset_out, 1'b1);
		wr(5'h00, 16'h0009);
		chk(bus_reset_out, 1'b0);
		n = 0;
		while (sof_pulse !== 1'b1 && n < 30000) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(n < 30000, 1'b1);
		rd(5'h03, 16'h0044);
		wr(5'h00, 16'h0008);
		peek(5'h0a);
		chk(last, 16'h2ee0);
		repeat (20) @(posedge core_clk);
		rd(5'h0a, 16'h2ee0);
		wr(5'h12, 16'h8002);
		wr(5'h13, 16'h8002);
		tok(`UODC_PID_IN, 2'h3, 1'b0, 1'b0, 10'h000, 1'b1, `UODC_HS_DATA);
		chk(tx_count, 16'h0002);
		$display("host mode done");
		chk(pp_pointer, 16'h005a);
		wr(5'h00, 16'h000a);
		wr(5'h00, 16'h0008);
		chk(pp_pointer, 16'h0000);
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		rd(5'h01, 16'h0000);
		chk(pp_pointer, 16'h0000);
		chk(dplus_pulldown_enable, 1'b0);
		$display("second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
